// [cprm_power_ctrl.sv]
// power-down registers, reset gating, identity readback and control-mode selection
//
// Functional notes
// R01: adc off bit 1 disables adc
// R02: bits 4:2 disable dac1..dac3, reset ones
// R03: every-dac bit 6 disables all dacs
// R04: bits 4 and 5 disable spdif tx, rx
// R05: bits 3,1,2,0 disable recovery, plls, oscillator
// R06: reset: all off bits set except osc, master
// R07: only master sleep turns references off
// R08: master sleep overrides everything, mutes outputs
// R09: host should power blocks down before master
// R10: bit 8 at 0x1d selects midrail impedance
// R11: registers held at defaults during power-on reset
// R12: writes before device ready are discarded
// R13: registers 0,1 give identity, 2 revision
// R14: no identity readback in continuous readback
// R15: hardware pin low software, high hardware
// R16: hardware mode runs register defaults only
// R17: software starts asleep; hardware follows sleep pin (code: software starts with block off bits set except osc, master sleep clear)
// R18: block off is own bit or master
// R19: protocol pin low two-wire, high three-wire
`timescale 1ns/10ps
`include "cprm_defs.svh"
module cprm_power_ctrl #(
  // arbitrary neutral identity values
  parameter logic [`CPRM_DATA_W-1:0] ID_LOW_VALUE   = 9'h05a,
  parameter logic [`CPRM_DATA_W-1:0] ID_HIGH_VALUE  = 9'h0c3,
  parameter logic [`CPRM_DATA_W-1:0] REVISION_VALUE = 9'h001
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  power_on_reset_n_in,
  input  wire logic                  hardware_select_pin_in,
  input  wire logic                  port_protocol_pin_in,
  input  wire logic                  all_sleep_pin_in,
  input  wire logic                  continuous_readback_in,
  input  wire cprm_pkg::cprm_wr_s    host_wr_in,
  input  wire cprm_pkg::cprm_rd_s    host_rd_in,
  output cprm_pkg::cprm_ans_s        host_ans_out,
  output logic                       device_ready_out,
  output logic                       hardware_mode_out,
  output logic                       three_wire_out,
  output logic                       adc_off_out,
  output logic [`CPRM_DAC_N-1:0]     dac_off_out,
  output logic                       spdif_tx_off_out,
  output logic                       spdif_rx_off_out,
  output logic                       clock_recovery_off_out,
  output logic                       first_pll_off_out,
  output logic                       second_pll_off_out,
  output logic                       osc_output_off_out,
  output logic                       reference_off_out,
  output logic                       outputs_mute_out,
  output logic                       midrail_impedance_select_out
);
  import cprm_pkg::*;

  localparam cprm_regs_s REGS_DEFAULT = '{
    master_sleep:             `CPRM_RST_MASTER,
    adc_off:                  `CPRM_RST_ADC,
    dac_off_bits:             `CPRM_RST_DAC,
    every_dac_off:            `CPRM_RST_EVERY_DAC,
    osc_output_off:           `CPRM_RST_OSC,
    first_pll_off:            `CPRM_RST_PLL_ONE,
    second_pll_off:           `CPRM_RST_PLL_TWO,
    clock_recovery_off:       `CPRM_RST_RECOVERY,
    spdif_tx_off:             `CPRM_RST_SPDIF_TX,
    spdif_rx_off:             `CPRM_RST_SPDIF_RX,
    midrail_impedance_select: `CPRM_RST_MIDRAIL
  };

  // identity registers share addresses with writable pll settings held elsewhere
  function automatic logic is_identity(input logic [`CPRM_ADDR_W-1:0] addr);
    is_identity = (addr == `CPRM_OFS_ID_LOW) || (addr == `CPRM_OFS_ID_HIGH) ||
                  (addr == `CPRM_OFS_REVISION);
  endfunction

  // pin synchronisers
  logic [`CPRM_PIN_N-1:0] pin_level;
  logic                   por_ready;
  logic                   hw_pin;
  logic                   proto_pin;
  logic                   sleep_pin;

  cprm_pin_sync u_pin_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      ({power_on_reset_n_in, hardware_select_pin_in,
                   port_protocol_pin_in, all_sleep_pin_in}),
    .level_out   (pin_level)
  );

  // power-on reset comes from an analogue monitor, so it is synchronised like a pin
  assign por_ready = pin_level[3];
  assign hw_pin    = pin_level[2];
  assign proto_pin = pin_level[1];
  assign sleep_pin = pin_level[0];

  // control state and registers
  cprm_state_e state_ff;
  cprm_state_e nxt_state;
  cprm_regs_s  regs_ff;
  cprm_regs_s  nxt_regs;
  logic        wr_take;

  always_comb begin
    nxt_state = state_ff;
    nxt_regs  = regs_ff;
    wr_take   = 1'h0;
    case (state_ff)
      CPRM_HELD: begin
        nxt_regs = REGS_DEFAULT;                            // [R11]
        if (por_ready) begin
          nxt_state = hw_pin ? CPRM_HARD : CPRM_SOFT;       // [R15]
        end
      end
      CPRM_SOFT: begin
        wr_take = host_wr_in.req;
        if (!por_ready) begin
          nxt_state = CPRM_HELD;
        end else if (hw_pin) begin
          nxt_state = CPRM_HARD;                            // [R15]
        end
      end
      CPRM_HARD: begin
        // the sleep pin steers every power-down; everything else stays at default
        nxt_regs = REGS_DEFAULT;                            // [R16]
        if (!por_ready) begin
          nxt_state = CPRM_HELD;
        end else if (!hw_pin) begin
          nxt_state = CPRM_SOFT;                            // [R15]
        end
      end
      default: begin
        nxt_state = CPRM_HELD;
        nxt_regs  = REGS_DEFAULT;
      end
    endcase
    // writes outside software mode, including before ready, are dropped
    if (wr_take && !(nxt_state == CPRM_HELD)) begin       // [R12]
      case (host_wr_in.addr)
        `CPRM_OFS_PWR_ONE: begin
          nxt_regs.master_sleep  = host_wr_in.data[`CPRM_POS_MASTER];
          nxt_regs.adc_off       = host_wr_in.data[`CPRM_POS_ADC];        // [R01]
          nxt_regs.dac_off_bits  =
            host_wr_in.data[`CPRM_POS_DAC_HI:`CPRM_POS_DAC_LO];           // [R02]
          nxt_regs.every_dac_off = host_wr_in.data[`CPRM_POS_EVERY_DAC];  // [R03]
        end
        `CPRM_OFS_PWR_TWO: begin
          nxt_regs.osc_output_off     = host_wr_in.data[`CPRM_POS_OSC];      // [R05]
          nxt_regs.first_pll_off      = host_wr_in.data[`CPRM_POS_PLL_ONE];  // [R05]
          nxt_regs.second_pll_off     = host_wr_in.data[`CPRM_POS_PLL_TWO];  // [R05]
          nxt_regs.clock_recovery_off = host_wr_in.data[`CPRM_POS_RECOVERY]; // [R05]
          nxt_regs.spdif_tx_off       = host_wr_in.data[`CPRM_POS_SPDIF_TX]; // [R04]
          nxt_regs.spdif_rx_off       = host_wr_in.data[`CPRM_POS_SPDIF_RX]; // [R04]
        end
        `CPRM_OFS_ADC_CTL: begin
          nxt_regs.midrail_impedance_select =
            host_wr_in.data[`CPRM_POS_MIDRAIL];                           // [R10]
        end
        default: begin
          nxt_regs = regs_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= CPRM_HELD;
      regs_ff  <= REGS_DEFAULT;                             // [R06]
    end else begin
      state_ff <= nxt_state;
      regs_ff  <= nxt_regs;
    end
  end

  // effective power-down outputs
  logic                   nxt_ready;
  logic                   nxt_hw_mode;
  logic                   nxt_three_wire;
  logic                   nxt_master;
  logic                   nxt_adc;
  logic [`CPRM_DAC_N-1:0] nxt_dac;
  logic                   nxt_tx;
  logic                   nxt_rx;
  logic                   nxt_recovery;
  logic                   nxt_pll_one;
  logic                   nxt_pll_two;
  logic                   nxt_osc;
  logic                   nxt_midrail;

  always_comb begin
    nxt_ready      = (state_ff != CPRM_HELD);
    nxt_hw_mode    = (state_ff == CPRM_HARD);
    // protocol pin only means something while the serial port is in use
    nxt_three_wire = (state_ff == CPRM_SOFT) && proto_pin;  // [R19]
    if (state_ff == CPRM_HARD) begin
      nxt_master = sleep_pin;                               // [R17]
      nxt_adc      = sleep_pin;
      nxt_dac      = {`CPRM_DAC_N{sleep_pin}};
      nxt_tx       = sleep_pin;
      nxt_rx       = sleep_pin;
      nxt_recovery = sleep_pin;
      nxt_pll_one  = sleep_pin;
      nxt_pll_two  = sleep_pin;
      nxt_osc      = sleep_pin;
      nxt_midrail  = REGS_DEFAULT.midrail_impedance_select; // [R16]
    end else begin
      nxt_master   = regs_ff.master_sleep;                  // [R08]
      nxt_adc      = regs_ff.adc_off | nxt_master;          // [R01] [R18]
      nxt_dac      = regs_ff.dac_off_bits |
                     {`CPRM_DAC_N{regs_ff.every_dac_off | nxt_master}}; // [R02] [R03] [R18]
      nxt_tx       = regs_ff.spdif_tx_off | nxt_master;     // [R04] [R18]
      nxt_rx       = regs_ff.spdif_rx_off | nxt_master;     // [R04] [R18]
      nxt_recovery = regs_ff.clock_recovery_off | nxt_master; // [R05] [R18]
      nxt_pll_one  = regs_ff.first_pll_off | nxt_master;    // [R05] [R18]
      nxt_pll_two  = regs_ff.second_pll_off | nxt_master;   // [R05] [R18]
      nxt_osc      = regs_ff.osc_output_off | nxt_master;   // [R05] [R18]
      nxt_midrail  = regs_ff.midrail_impedance_select;      // [R10]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      device_ready_out             <= 1'h0;
      hardware_mode_out            <= 1'h0;
      three_wire_out               <= 1'h0;
      adc_off_out                  <= `CPRM_RST_ADC;
      dac_off_out                  <= `CPRM_RST_DAC;
      spdif_tx_off_out             <= `CPRM_RST_SPDIF_TX;
      spdif_rx_off_out             <= `CPRM_RST_SPDIF_RX;
      clock_recovery_off_out       <= `CPRM_RST_RECOVERY;
      first_pll_off_out            <= `CPRM_RST_PLL_ONE;
      second_pll_off_out           <= `CPRM_RST_PLL_TWO;
      osc_output_off_out           <= `CPRM_RST_OSC;
      reference_off_out            <= `CPRM_RST_MASTER;
      outputs_mute_out             <= `CPRM_RST_MASTER;
      midrail_impedance_select_out <= `CPRM_RST_MIDRAIL;
    end else begin
      device_ready_out             <= nxt_ready;
      hardware_mode_out            <= nxt_hw_mode;
      three_wire_out               <= nxt_three_wire;
      adc_off_out                  <= nxt_adc;
      dac_off_out                  <= nxt_dac;
      spdif_tx_off_out             <= nxt_tx;
      spdif_rx_off_out             <= nxt_rx;
      clock_recovery_off_out       <= nxt_recovery;
      first_pll_off_out            <= nxt_pll_one;
      second_pll_off_out           <= nxt_pll_two;
      osc_output_off_out           <= nxt_osc;
      reference_off_out            <= nxt_master;           // [R07]
      outputs_mute_out             <= nxt_master;           // [R08]
      midrail_impedance_select_out <= nxt_midrail;
    end
  end

  // identity readback; everything else is write-only and reads as zero
  cprm_ans_s nxt_ans;

  always_comb begin
    nxt_ans       = '0;
    nxt_ans.valid = host_rd_in.req;
    if (host_rd_in.req && !continuous_readback_in && is_identity(host_rd_in.addr)) begin // [R14]
      case (host_rd_in.addr)
        `CPRM_OFS_ID_LOW:   nxt_ans.data = ID_LOW_VALUE;    // [R13]
        `CPRM_OFS_ID_HIGH:  nxt_ans.data = ID_HIGH_VALUE;   // [R13]
        `CPRM_OFS_REVISION: nxt_ans.data = REVISION_VALUE;  // [R13]
        default:            nxt_ans.data = 9'h000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      host_ans_out <= '0;
    end else begin
      host_ans_out <= nxt_ans;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_reset_defaults: // [R06]
    assert property ($fell(sys_rst_in) |-> regs_ff == REGS_DEFAULT)
    else $error("registers not at defaults after reset");

  a_held_defaults: // [R11]
    assert property (state_ff == CPRM_HELD |=> regs_ff == REGS_DEFAULT)
    else $error("registers moved while held in power-on reset");

  a_early_write_dropped: // [R12]
    assert property (state_ff == CPRM_HELD && host_wr_in.req |=> regs_ff == REGS_DEFAULT)
    else $error("write taken before device ready");

  a_adc_follow: // [R01]
    assert property (state_ff == CPRM_SOFT |=>
                     adc_off_out == $past(regs_ff.adc_off | regs_ff.master_sleep))
    else $error("adc power-down does not follow its bit");

  a_dac_each: // [R02]
    assert property (state_ff == CPRM_SOFT && !regs_ff.every_dac_off &&
                     !regs_ff.master_sleep |=> dac_off_out == $past(regs_ff.dac_off_bits))
    else $error("dac power-down does not follow per-dac bits");

  a_every_dac: // [R03]
    assert property (state_ff == CPRM_SOFT && regs_ff.every_dac_off |=> dac_off_out == 3'h7)
    else $error("every-dac override not applied");

  a_spdif_off: // [R04]
    assert property (state_ff == CPRM_SOFT |=>
                     spdif_tx_off_out == $past(regs_ff.spdif_tx_off | regs_ff.master_sleep) &&
                     spdif_rx_off_out == $past(regs_ff.spdif_rx_off | regs_ff.master_sleep))
    else $error("spdif power-down mismatch");

  a_clock_blocks: // [R05]
    assert property (state_ff == CPRM_SOFT && !regs_ff.master_sleep |=>
                     {clock_recovery_off_out, first_pll_off_out, second_pll_off_out,
                      osc_output_off_out} ==
                     $past({regs_ff.clock_recovery_off, regs_ff.first_pll_off,
                            regs_ff.second_pll_off, regs_ff.osc_output_off}))
    else $error("clock block power-down mismatch");

  a_reference_master: // [R07]
    assert property (state_ff == CPRM_SOFT && !regs_ff.master_sleep |=> !reference_off_out)
    else $error("references off without master sleep");

  a_master_override: // [R08] [R18]
    assert property (state_ff == CPRM_SOFT && regs_ff.master_sleep |=>
                     adc_off_out && dac_off_out == 3'h7 && spdif_tx_off_out &&
                     spdif_rx_off_out && osc_output_off_out && outputs_mute_out &&
                     reference_off_out)
    else $error("master sleep does not override");

  a_midrail_select: // [R10]
    assert property (state_ff == CPRM_SOFT && host_wr_in.req &&
                     host_wr_in.addr == `CPRM_OFS_ADC_CTL && por_ready && !hw_pin
                     ##2 1'b1 |-> midrail_impedance_select_out ==
                     $past(host_wr_in.data[`CPRM_POS_MIDRAIL], 2))
    else $error("midrail select not applied two cycles after write");

  a_identity_read: // [R13]
    assert property (host_rd_in.req && !continuous_readback_in &&
                     host_rd_in.addr == `CPRM_OFS_ID_HIGH |=>
                     host_ans_out.valid && host_ans_out.data == ID_HIGH_VALUE)
    else $error("identity read wrong");

  a_identity_blocked: // [R14]
    assert property (host_rd_in.req && continuous_readback_in |=>
                     host_ans_out.valid && host_ans_out.data == 9'h000)
    else $error("identity readable in continuous readback");

  a_mode_entry: // [R15]
    assert property (state_ff == CPRM_HELD && por_ready |=>
                     state_ff == ($past(hw_pin) ? CPRM_HARD : CPRM_SOFT))
    else $error("wrong control mode after ready");

  a_hard_sleep: // [R16] [R17]
    assert property (state_ff == CPRM_HARD |=>
                     adc_off_out == $past(sleep_pin) && midrail_impedance_select_out)
    else $error("hardware mode power does not follow sleep pin");

  a_protocol_pin: // [R19]
    assert property (1'b1 |=> three_wire_out == $past(state_ff == CPRM_SOFT && proto_pin))
    else $error("protocol selection mismatch");
endmodule // cprm_power_ctrl

// [cprm_defs.svh]
// offsets, field positions, reset values and widths of the power and mode block
`ifndef CPRM_DEFS_SVH
`define CPRM_DEFS_SVH

`define CPRM_ADDR_W        7
`define CPRM_DATA_W        9
`define CPRM_DAC_N         3

`define CPRM_OFS_ID_LOW    7'h00
`define CPRM_OFS_ID_HIGH   7'h01
`define CPRM_OFS_REVISION  7'h02
`define CPRM_OFS_ADC_CTL   7'h1d
`define CPRM_OFS_PWR_ONE   7'h32
`define CPRM_OFS_PWR_TWO   7'h33

`define CPRM_POS_MASTER    0
`define CPRM_POS_ADC       1
`define CPRM_POS_DAC_LO    2
`define CPRM_POS_DAC_HI    4
`define CPRM_POS_EVERY_DAC 6

`define CPRM_POS_OSC       0
`define CPRM_POS_PLL_ONE   1
`define CPRM_POS_PLL_TWO   2
`define CPRM_POS_RECOVERY  3
`define CPRM_POS_SPDIF_TX  4
`define CPRM_POS_SPDIF_RX  5

`define CPRM_POS_MIDRAIL   8

`define CPRM_RST_MASTER    1'h0
`define CPRM_RST_ADC       1'h1
`define CPRM_RST_DAC       3'h7
`define CPRM_RST_EVERY_DAC 1'h1
`define CPRM_RST_OSC       1'h0
`define CPRM_RST_PLL_ONE   1'h1
`define CPRM_RST_PLL_TWO   1'h1
`define CPRM_RST_RECOVERY  1'h1
`define CPRM_RST_SPDIF_TX  1'h1
`define CPRM_RST_SPDIF_RX  1'h1
`define CPRM_RST_MIDRAIL   1'h1

`define CPRM_PIN_N         4

`endif

// [cprm_pkg.sv]
// types shared by the power, reset and mode control block
package cprm_pkg;
  `include "cprm_defs.svh"

  typedef struct packed {
    logic                      req;
    logic [`CPRM_ADDR_W-1:0]   addr;
    logic [`CPRM_DATA_W-1:0]   data;
  } cprm_wr_s;

  typedef struct packed {
    logic                      req;
    logic [`CPRM_ADDR_W-1:0]   addr;
  } cprm_rd_s;

  typedef struct packed {
    logic                      valid;
    logic [`CPRM_DATA_W-1:0]   data;
  } cprm_ans_s;

  typedef struct packed {
    logic                      master_sleep;
    logic                      adc_off;
    logic [`CPRM_DAC_N-1:0]    dac_off_bits;
    logic                      every_dac_off;
    logic                      osc_output_off;
    logic                      first_pll_off;
    logic                      second_pll_off;
    logic                      clock_recovery_off;
    logic                      spdif_tx_off;
    logic                      spdif_rx_off;
    logic                      midrail_impedance_select;
  } cprm_regs_s;

  typedef enum logic [2:0] {
    CPRM_HELD = 3'h1,
    CPRM_SOFT = 3'h2,
    CPRM_HARD = 3'h4
  } cprm_state_e;
endpackage

// [cprm_pin_sync.sv]
// three-stage synchroniser for the mode and reset pins
`timescale 1ns/10ps
`include "cprm_defs.svh"
module cprm_pin_sync (
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic [`CPRM_PIN_N-1:0] pin_in,
  output logic      [`CPRM_PIN_N-1:0] level_out
);
  import cprm_pkg::*;

  logic [`CPRM_PIN_N-1:0] meta_ff;
  logic [`CPRM_PIN_N-1:0] mid_ff;
  logic [`CPRM_PIN_N-1:0] last_ff;
  logic [`CPRM_PIN_N-1:0] level_ff;
  logic [`CPRM_PIN_N-1:0] nxt_level;

  // a change only counts once the second and third stage agree
  always_comb begin
    nxt_level = level_ff;
    for (int i = 0; i < `CPRM_PIN_N; i++) begin
      if (mid_ff[i] == last_ff[i]) begin
        nxt_level[i] = last_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_ff  <= '0;
      mid_ff   <= '0;
      last_ff  <= '0;
      level_ff <= '0;
    end else begin
      meta_ff  <= pin_in;
      mid_ff   <= meta_ff;
      last_ff  <= mid_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;
endmodule // cprm_pin_sync

// [cprm_host_model.sv]
// host controller model on the register port
`timescale 1ns/10ps
`include "cprm_defs.svh"
module cprm_host_model (
  input  wire logic                core_clk_in,
  output cprm_pkg::cprm_wr_s       wr_out,
  output cprm_pkg::cprm_rd_s       rd_out,
  input  wire cprm_pkg::cprm_ans_s ans_in
);
  import cprm_pkg::*;
  initial begin
    wr_out = '0;
    rd_out = '0;
  end
  // idle fields show the inverse, so a stale value can never pass as live
  task automatic wr_reg(input logic [`CPRM_ADDR_W-1:0] a, input logic [`CPRM_DATA_W-1:0] d);
    @(posedge core_clk_in);
    #1 wr_out = '{req: 1'b1, addr: a, data: d};
    @(posedge core_clk_in);
    #1 wr_out = '{req: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic rd_reg(input logic [`CPRM_ADDR_W-1:0] a, output logic [`CPRM_DATA_W:0] v);
    @(posedge core_clk_in);
    #1 rd_out = '{req: 1'b1, addr: a};
    @(posedge core_clk_in);
    #1 v = ans_in;
    rd_out = '{req: 1'b0, addr: ~a};
  endtask
endmodule // cprm_host_model

// [cprm_power_ctrl_bench.sv]
// self-checking bench for the power, reset and mode control block
`timescale 1ns/10ps
`include "cprm_defs.svh"
module cprm_power_ctrl_bench;
  import cprm_pkg::*;
  // arbitrary identity values
  localparam logic [8:0] ID_L = 9'h05a;
  localparam logic [8:0] ID_H = 9'h0c3;
  localparam logic [8:0] REV  = 9'h001;
  localparam logic [8:0] IDS [4] = '{ID_L, ID_H, REV, 9'h000};
  typedef struct packed {logic [6:0] a; logic [8:0] d; logic [12:0] e;} cprm_row_s;
  localparam cprm_row_s ROWS [13] = '{
    '{7'h32, 9'h000, 13'h01f1},
    '{7'h32, 9'h014, 13'h0bf1},
    '{7'h32, 9'h040, 13'h0ff1},
    '{7'h32, 9'h002, 13'h11f1},
    '{7'h33, 9'h000, 13'h1001},
    '{7'h33, 9'h031, 13'h1189},
    '{7'h33, 9'h00e, 13'h1071},
    '{7'h1d, 9'h000, 13'h1070},
    '{7'h1d, 9'h100, 13'h1071},
    '{7'h7f, 9'h1ff, 13'h1071},
    '{7'h32, 9'h05e, 13'h1e71},
    '{7'h32, 9'h001, 13'h1fff},
    '{7'h32, 9'h000, 13'h0071}
  };
  logic       clk, rst, por_n, hw_pin, proto_pin, sleep_pin, cont_rd;
  cprm_wr_s   wr;
  cprm_rd_s   rd;
  cprm_ans_s  ans;
  logic       ready, hw_mode, three_w, adc, tx, rx, rec, p1, p2, osc, ref_off, mute, mid;
  logic [2:0] dac;
  logic [9:0] rv;
  int         error_cnt, comparisons, cyc;
  wire logic [12:0] pwr = {adc, dac, tx, rx, rec, p1, p2, osc, ref_off, mute, mid};

  cprm_power_ctrl #(.ID_LOW_VALUE(ID_L), .ID_HIGH_VALUE(ID_H), .REVISION_VALUE(REV)) dut (
    .core_clk_in(clk), .sys_rst_in(rst), .power_on_reset_n_in(por_n),
    .hardware_select_pin_in(hw_pin), .port_protocol_pin_in(proto_pin),
    .all_sleep_pin_in(sleep_pin), .continuous_readback_in(cont_rd),
    .host_wr_in(wr), .host_rd_in(rd), .host_ans_out(ans),
    .device_ready_out(ready), .hardware_mode_out(hw_mode), .three_wire_out(three_w),
    .adc_off_out(adc), .dac_off_out(dac), .spdif_tx_off_out(tx), .spdif_rx_off_out(rx),
    .clock_recovery_off_out(rec), .first_pll_off_out(p1), .second_pll_off_out(p2),
    .osc_output_off_out(osc), .reference_off_out(ref_off), .outputs_mute_out(mute),
    .midrail_impedance_select_out(mid));
  cprm_host_model host (.core_clk_in(clk), .wr_out(wr), .rd_out(rd), .ans_in(ans));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      complete_run;
    end
  end

  task automatic chk_pwr(input string n, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_data(input string n, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded, so a device stuck in hold ends as a mismatch instead of a hang
  task automatic wait_ready;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) settle(1);
    chk_data("device ready", 9'h001, {8'h0, ready});
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 0; rst = 1; por_n = 0; hw_pin = 0; proto_pin = 0; sleep_pin = 0; cont_rd = 0;
    error_cnt = 0; comparisons = 0; cyc = 0;
    settle(3);
    rst = 0;
    chk_pwr("reset defaults", 13'h1ff1, pwr);
    host.wr_reg(7'h32, 9'h000);
    settle(2);
    chk_pwr("write while held", 13'h1ff1, pwr);
    chk_data("ready while held", 9'h000, {8'h0, ready});
    por_n = 1;
    wait_ready;
    chk_data("protocol low", 9'h000, {8'h0, three_w});
    // rows build on each other; row 10 powers blocks down before master sleep
    for (int i = 0; i < 13; i++) begin
      host.wr_reg(ROWS[i].a, ROWS[i].d);
      settle(1);
      chk_pwr("power outputs", ROWS[i].e, pwr);
    end
    for (int i = 0; i < 4; i++) begin
      host.rd_reg(7'(i), rv);
      chk_data("identity read", IDS[i], rv[8:0]);
      chk_data("answer valid", 9'h001, {8'h0, rv[9]});
    end
    cont_rd = 1;
    host.rd_reg(7'h00, rv);
    chk_data("read in continuous mode", 9'h000, rv[8:0]);
    cont_rd = 0;
    proto_pin = 1;
    settle(8);
    chk_data("protocol high", 9'h001, {8'h0, three_w});
    hw_pin = 1;
    settle(8);
    chk_data("hardware mode", 9'h001, {8'h0, hw_mode});
    chk_data("no protocol in hardware", 9'h000, {8'h0, three_w});
    chk_pwr("hardware awake", 13'h0001, pwr);
    host.wr_reg(7'h32, 9'h1ff);
    settle(2);
    chk_pwr("write in hardware mode", 13'h0001, pwr);
    sleep_pin = 1;
    settle(8);
    chk_pwr("hardware asleep", 13'h1fff, pwr);
    sleep_pin = 0;
    hw_pin = 0;
    settle(8);
    chk_data("software mode", 9'h000, {8'h0, hw_mode});
    chk_pwr("software starts down", 13'h1ff1, pwr);
    host.wr_reg(7'h32, 9'h000);
    settle(1);
    chk_pwr("wake after return", 13'h01f1, pwr);
    por_n = 0;
    settle(8);
    chk_pwr("defaults on power-on reset", 13'h1ff1, pwr);
    chk_data("ready dropped", 9'h000, {8'h0, ready});
    host.wr_reg(7'h32, 9'h000);
    settle(2);
    chk_pwr("write after power-on reset", 13'h1ff1, pwr);
    complete_run;
  end
endmodule // cprm_power_ctrl_bench
